// ===== include/dpcp_pkg.sv
`default_nettype none
package dpcp_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CURSOR_BASE = 8'h04;
   localparam logic [7:0] REG_CURSOR_POS = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_CURSOR_DATA = 8'h10;
   // Control fields and register reset values
   localparam int CTRL_DEPTH_LSB = 0;
   localparam int CTRL_SEL_EN = 2;
   localparam int CTRL_CURSOR_EN = 3;
   localparam int CTRL_FLICKER_EN = 4;
   localparam int CTRL_LANE_LSB = 5;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] BASE_RESET = 32'h0000_0000;
   localparam logic [31:0] POS_RESET = 32'h0000_0000;
   // Pixel depth codes
   localparam logic [1:0] DEPTH_8 = 2'h0;
   localparam logic [1:0] DEPTH_555 = 2'h1;
   localparam logic [1:0] DEPTH_565 = 2'h2;
   localparam logic [1:0] DEPTH_32 = 2'h3;
   // Cursor geometry and pattern codes; pixel bypass bits
   localparam int CURSOR_DIM = 32;
   localparam int CURSOR_WORDS = CURSOR_DIM * CURSOR_DIM;
   localparam int CURSOR_BYTES = 2048;
   localparam logic [15:0] CURSOR_CLEAR = 16'h0000;
   localparam logic [15:0] CURSOR_INVERT = 16'h7FFF;
   localparam int REPLACE_BIT = 15;
   localparam int BYPASS_BIT32 = 31;
   localparam int BYPASS_BIT16 = 15;

   typedef struct packed {
      logic [9:0] r;
      logic [9:0] g;
      logic [9:0] b;
   } dpcp_rgb_t;

   typedef struct packed {
      logic valid;
      logic [10:0] x;
      logic [10:0] y;
      logic is_video;
      logic gamma;
      dpcp_rgb_t rgb;
   } dpcp_pix_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WDATA = 3'b010,
      ST_RESP = 3'b100
   } dpcp_wstate_t;
endpackage
`default_nettype wire

// ===== hdl/dpcp_cursor_ram.sv
`timescale 1ns/100ps
`default_nettype none
module dpcp_cursor_ram #(
   parameter int DEPTH = 1024,
   parameter int AW = 10
) (
   // Clock
   input wire logic aclk,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [15:0] wdata,
   // Read port
   input wire logic [AW-1:0] raddr,
   output logic [15:0] rdata
);
   logic [15:0] mem [DEPTH];

   always_ff @(posedge aclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // dpcp_cursor_ram
`default_nettype wire

// ===== hdl/dpcp_flicker.sv
`timescale 1ns/100ps
`default_nettype none
module dpcp_flicker #(
   parameter int MAX_W = 2048,
   parameter int XW = 11
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic enable,
   // Stream in
   input wire logic in_valid,
   input wire logic [XW-1:0] in_x,
   input wire logic in_graphics,
   input wire dpcp_pkg::dpcp_rgb_t in_rgb,
   // Stream out, one cycle later
   output dpcp_pkg::dpcp_rgb_t out_rgb
);
   // Two line stores; the middle line is output, weights 1/4,1/2,1/4.
   // Output is therefore one line late relative to input.
   dpcp_pkg::dpcp_rgb_t line_a [MAX_W];
   dpcp_pkg::dpcp_rgb_t line_b [MAX_W];

   function automatic logic [9:0] mix(input logic [9:0] t, input logic [9:0] c,
                                      input logic [9:0] d);
      logic [11:0] s;
      s = {2'h0, t} + {1'h0, c, 1'h0} + {2'h0, d};
      mix = s[11:2];
   endfunction

   always_ff @(posedge aclk) begin
      if (in_valid) begin
         line_b[in_x] <= line_a[in_x];
         line_a[in_x] <= in_rgb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_rgb <= '0;
      end else if (!(enable && in_graphics)) begin
         out_rgb <= in_rgb; // RQ15
      end else begin
         out_rgb.r <= mix(line_b[in_x].r, line_a[in_x].r, in_rgb.r); // RQ13 RQ14
         out_rgb.g <= mix(line_b[in_x].g, line_a[in_x].g, in_rgb.g); // RQ13 RQ14
         out_rgb.b <= mix(line_b[in_x].b, line_a[in_x].b, in_rgb.b); // RQ13 RQ14
      end
   end
endmodule // dpcp_flicker
`default_nettype wire

// ===== hdl/dpcp_pixel_path.sv
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RQ1: Pixel bit 31 picks gamma table path (clear) or direct DAC path (set).
// RQ2: Bypass colour: bytes give bits 9:2, bits 29:24 give low bit pairs.
// RQ3: Wider framebuffer words are repeated 32-bit words, little-endian lanes.
// RQ4: Software keeps line lengths a multiple of 4, 2 or 1 pixels.
// RQ5: Cursor is 32x32 pixels, 5:5:5 colour plus one mode bit.
// RQ6: Cursor pattern is a 2 KB bitmap at a programmed base.
// RQ7: Cursor components widen to 10 bits by repeating the 5 bits.
// RQ8: Replace bit set replaces pixel; clear XORs widened colour in.
// RQ9: All-zero cursor pixel is transparent.
// RQ10: Colour 0x7FFF with replace clear inverts the display pixel.
// RQ11: Cursor merges after video overlay, so it sits on top.
// RQ12: Software changes cursor only in flyback and disables it when idle.
// RQ13: Flicker filter mixes pixel with neighbours above and below, centre heaviest.
// RQ14: Flicker weights sum to one so nothing clips.
// RQ15: Flicker filter touches only framebuffer graphics pixels.
// RQ16: 5:5:5 selection uses bit 15; otherwise 16-bit modes bypass the table.
// RQ17: Cursor disabled or outside its area leaves the pixel alone.
// RQ18: Bypassed pixel with zero low bits serves as 8:8:8 output.
module dpcp_pixel_path #(
   parameter int FB_WIDTH = 128,
   parameter int MAX_W = 2048
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Framebuffer pixel word stream
   input wire logic fb_valid,
   input wire logic [FB_WIDTH-1:0] fb_data,
   input wire logic [10:0] fb_x,
   input wire logic [10:0] fb_y,
   input wire logic fb_vblank,
   // Video overlay pixel, already keyed
   input wire logic ovl_active,
   input wire dpcp_pkg::dpcp_rgb_t ovl_rgb,
   // DAC side
   output logic dac_valid,
   output logic dac_gamma,
   output dpcp_pkg::dpcp_rgb_t dac_rgb,
   // Cursor fetch address into framebuffer memory
   output logic [31:0] cursor_fetch_addr
);
   localparam int LANES = FB_WIDTH / 32;

   typedef struct packed {
      logic aw_ok;
      logic w_ok;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [31:0] ctrl;
      logic [31:0] cbase;
      logic [31:0] cpos;
      logic [9:0] cidx;
      logic cwe;
      logic [15:0] cwdata;
      logic [9:0] cwaddr;
      dpcp_pkg::dpcp_pix_t p1;
      dpcp_pkg::dpcp_pix_t p2;
      logic dac_valid;
      logic dac_gamma;
      dpcp_pkg::dpcp_rgb_t dac_rgb;
   } dpcp_state_t;

   dpcp_state_t s, next_s;
   logic [15:0] cursor_pix;
   logic [9:0] cursor_raddr;
   dpcp_pkg::dpcp_rgb_t flt_rgb;

   function automatic logic [9:0] widen5(input logic [4:0] c);
      widen5 = {c, c}; // RQ7
   endfunction

   function automatic logic [31:0] lane_of(input logic [FB_WIDTH-1:0] d,
                                           input logic [1:0] lane);
      lane_of = d[32*(int'(lane) % LANES) +: 32]; // RQ3
   endfunction

   // Cursor coordinates relative to the programmed position. Stage 1
   // addresses the store, so the registered word meets the filter output.
   logic [10:0] cx, cy;
   logic in_cursor;
   always_comb begin
      cx = s.p1.x - s.cpos[10:0];
      cy = s.p1.y - s.cpos[26:16];
      in_cursor = (s.p1.x >= s.cpos[10:0]) && (s.p1.y >= s.cpos[26:16]) &&
                  (cx < 11'(dpcp_pkg::CURSOR_DIM)) && (cy < 11'(dpcp_pkg::CURSOR_DIM)); // RQ5
      cursor_raddr = {cy[4:0], cx[4:0]};
   end

   dpcp_cursor_ram #(
      .DEPTH(dpcp_pkg::CURSOR_WORDS),
      .AW(10)
   ) u_cram (
      .aclk(aclk),
      .we(s.cwe),
      .waddr(s.cwaddr),
      .wdata(s.cwdata),
      .raddr(cursor_raddr),
      .rdata(cursor_pix)
   );

   dpcp_flicker #(
      .MAX_W(MAX_W),
      .XW(11)
   ) u_flick (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(s.ctrl[dpcp_pkg::CTRL_FLICKER_EN]),
      .in_valid(s.p1.valid),
      .in_x(s.p1.x),
      .in_graphics(!s.p1.is_video),
      .in_rgb(s.p1.rgb),
      .out_rgb(flt_rgb)
   );

   // Hit flag registered beside the store read, so both describe stage 2
   logic cur_hit;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cur_hit <= 1'b0;
      end else begin
         cur_hit <= in_cursor && s.ctrl[dpcp_pkg::CTRL_CURSOR_EN];
      end
   end

   always_comb begin
      logic [31:0] w;
      logic [1:0] depth;
      logic [15:0] h;
      dpcp_pkg::dpcp_rgb_t base, cur;
      logic hit_d;
      w = lane_of(fb_data, s.ctrl[dpcp_pkg::CTRL_LANE_LSB +: 2]);
      depth = s.ctrl[dpcp_pkg::CTRL_DEPTH_LSB +: 2];
      h = '0;
      base = '0;
      cur = '0;
      hit_d = 1'b0;
      next_s = s;
      // Register bus: write address and data in either order
      if (s_axi_awvalid && !s.aw_ok) begin
         next_s.aw_ok = 1'b1;
         next_s.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s.w_ok) begin
         next_s.w_ok = 1'b1;
         next_s.wdata = s_axi_wdata;
      end
      next_s.cwe = 1'b0;
      if (s.aw_ok && s.w_ok && !s.bvalid) begin
         next_s.aw_ok = 1'b0;
         next_s.w_ok = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = 2'h0;
         case (s.awaddr)
            dpcp_pkg::REG_CTRL: next_s.ctrl = s.wdata;
            dpcp_pkg::REG_CURSOR_BASE: next_s.cbase = s.wdata; // RQ6
            dpcp_pkg::REG_CURSOR_POS: next_s.cpos = s.wdata;
            dpcp_pkg::REG_CURSOR_DATA: begin
               // Pattern loaded word by word; index auto-increments
               next_s.cwe = 1'b1;
               next_s.cwaddr = s.cidx;
               next_s.cwdata = s.wdata[15:0];
               next_s.cidx = s.cidx + 10'h001;
            end
            // Status write rewinds the pattern load index
            dpcp_pkg::REG_STATUS: next_s.cidx = '0;
            default: next_s.bresp = 2'h2;
         endcase
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s_axi_arvalid && !s.rvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = 2'h0;
         case (s_axi_araddr)
            dpcp_pkg::REG_CTRL: next_s.rdata = s.ctrl;
            dpcp_pkg::REG_CURSOR_BASE: next_s.rdata = s.cbase;
            dpcp_pkg::REG_CURSOR_POS: next_s.rdata = s.cpos;
            dpcp_pkg::REG_STATUS: next_s.rdata = {21'h0, fb_vblank, s.cidx};
            default: begin
               next_s.rdata = '0;
               next_s.rresp = 2'h2;
            end
         endcase
      end else if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      // Stage 1: unpack framebuffer pixel
      next_s.p1.valid = fb_valid;
      next_s.p1.x = fb_x;
      next_s.p1.y = fb_y;
      next_s.p1.is_video = ovl_active;
      case (depth)
         dpcp_pkg::DEPTH_32: begin
            next_s.p1.gamma = !w[dpcp_pkg::BYPASS_BIT32]; // RQ1
            if (w[dpcp_pkg::BYPASS_BIT32]) begin
               next_s.p1.rgb = {w[23:16], w[29:28], w[15:8], w[27:26],
                                w[7:0], w[25:24]}; // RQ2 RQ18
            end else begin
               next_s.p1.rgb = {w[23:16], 2'h0, w[15:8], 2'h0, w[7:0], 2'h0}; // RQ1
            end
         end
         dpcp_pkg::DEPTH_555: begin
            h = w[15:0];
            next_s.p1.gamma = s.ctrl[dpcp_pkg::CTRL_SEL_EN] && !h[dpcp_pkg::BYPASS_BIT16]; // RQ16
            next_s.p1.rgb = {widen5(h[14:10]), widen5(h[9:5]), widen5(h[4:0])};
         end
         dpcp_pkg::DEPTH_565: begin
            h = w[15:0];
            next_s.p1.gamma = 1'b0; // RQ16
            next_s.p1.rgb = {widen5(h[15:11]), h[10:5], h[10:7], widen5(h[4:0])};
         end
         default: begin
            next_s.p1.gamma = 1'b1;
            next_s.p1.rgb = {w[7:0], 2'h0, w[7:0], 2'h0, w[7:0], 2'h0};
         end
      endcase
      // Overlay replaces graphics before the cursor merge
      if (ovl_active) begin
         next_s.p1.rgb = ovl_rgb; // RQ11
         next_s.p1.gamma = 1'b0;
      end
      // Stage 2 keeps the attributes; its colour is the filter output,
      // which took this same pixel from stage 1 at the last edge
      next_s.p2 = s.p1;
      hit_d = cur_hit;
      // Stage 3: cursor merge, applied after filter and overlay
      cur = {widen5(cursor_pix[14:10]), widen5(cursor_pix[9:5]),
             widen5(cursor_pix[4:0])}; // RQ7
      base = flt_rgb; // RQ15
      next_s.dac_valid = s.p2.valid;
      next_s.dac_gamma = s.p2.gamma;
      if (!hit_d || cursor_pix == dpcp_pkg::CURSOR_CLEAR) begin
         next_s.dac_rgb = base; // RQ9 RQ17
      end else if (cursor_pix[dpcp_pkg::REPLACE_BIT]) begin
         next_s.dac_rgb = cur; // RQ8
         next_s.dac_gamma = 1'b0;
      end else begin
         next_s.dac_rgb = base ^ cur; // RQ8 RQ10
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.ctrl <= dpcp_pkg::CTRL_RESET;
         s.cbase <= dpcp_pkg::BASE_RESET;
         s.cpos <= dpcp_pkg::POS_RESET;
      end else begin
         s <= next_s;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cursor_fetch_addr <= '0;
      end else begin
         // Two bytes per pattern word
         cursor_fetch_addr <= s.cbase + {21'h0, s.cidx, 1'b0}; // RQ6
      end
   end

   // Ready is high while the matching holding slot is empty
   assign s_axi_awready = !s.aw_ok;
   assign s_axi_wready = !s.w_ok;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = !s.rvalid;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign dac_valid = s.dac_valid;
   assign dac_gamma = s.dac_gamma;
   assign dac_rgb = s.dac_rgb;
endmodule // dpcp_pixel_path
`default_nettype wire

// ===== tb/dpcp_pp_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module dpcp_pp_asserts #(
   parameter int FB_WIDTH = 128,
   parameter int MAX_W = 2048
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pixel path
   input wire logic fb_valid,
   input wire logic [FB_WIDTH-1:0] fb_data,
   input wire logic ovl_active,
   input wire dpcp_pkg::dpcp_rgb_t ovl_rgb,
   input wire logic dac_valid,
   input wire logic dac_gamma,
   input wire dpcp_pkg::dpcp_rgb_t dac_rgb
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] aw_q;
   logic [31:0] w_q;
   logic [31:0] ctrl_q;
   logic [31:0] lw;
   logic exp_g;
   dpcp_pkg::dpcp_rgb_t byp;
   // Shadow of the control word, committed at the write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= dpcp_pkg::CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= s_axi_wdata;
         end
         if (s_axi_bvalid && s_axi_bready && aw_q == dpcp_pkg::REG_CTRL) begin
            ctrl_q <= w_q;
         end
      end
   end
   always_comb begin
      lw = fb_data[(ctrl_q[6:5] % (FB_WIDTH / 32)) * 32 +: 32];
      byp = {lw[23:16], lw[29:28], lw[15:8], lw[27:26], lw[7:0], lw[25:24]};
      case (ctrl_q[1:0])
         dpcp_pkg::DEPTH_8: exp_g = 1'h1;
         dpcp_pkg::DEPTH_555: exp_g = ctrl_q[2] & ~lw[15];
         dpcp_pkg::DEPTH_565: exp_g = 1'h0;
         default: exp_g = ~lw[31];
      endcase
   end
   pix_lat_a: assert property (dac_valid == $past(fb_valid, 3))
      else $error("dac_valid not three cycles after fb_valid");
   gam_sel_a: assert property (fb_valid && ctrl_q[4:3] == 2'h0 && !ovl_active
      |-> ##3 dac_gamma == $past(exp_g, 3))
      else $error("gamma route wrong");
   byp_map_a: assert property (fb_valid && ctrl_q[1:0] == 2'h3 && lw[31]
      && ctrl_q[4:3] == 2'h0 && !ovl_active |-> ##3 dac_rgb == $past(byp, 3))
      else $error("bypass colour mapping wrong");
   ovl_pass_a: assert property (fb_valid && ovl_active && !ctrl_q[3]
      |-> ##3 dac_rgb == $past(ovl_rgb, 3))
      else $error("overlay pixel altered");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer changed early");
   bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
      |-> ##[1:4] s_axi_rvalid && s_axi_rresp == 2'h2)
      else $error("unmapped read not refused");
   r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answered twice");
   cover property (fb_valid && ctrl_q[3]);
   cover property (fb_valid && ctrl_q[4] && ovl_active);
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // dpcp_pp_asserts
bind dpcp_pixel_path dpcp_pp_asserts #(.FB_WIDTH(FB_WIDTH), .MAX_W(MAX_W)) chk_u (.*);
`default_nettype wire

// ===== tb/dpcp_dac_model.sv
`timescale 1ns/100ps
`default_nettype none
module dpcp_dac_model (
   // DAC inputs
   input wire logic aclk,
   input wire logic dac_valid,
   input wire logic dac_gamma,
   input wire dpcp_pkg::dpcp_rgb_t dac_rgb
);
   logic [30:0] got[$];
   // Converters take a sample every valid cycle, no back-pressure
   always @(posedge aclk) begin
      if (dac_valid === 1'h1) begin
         got.push_back({dac_gamma, dac_rgb});
      end
   end
endmodule // dpcp_dac_model
`default_nettype wire

// ===== tb/dpcp_pixel_path_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
   $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module dpcp_pixel_path_tb;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'h0;
   logic s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, cursor_fetch_addr, rd;
   logic fb_valid = 1'h0;
   logic fb_vblank = 1'h0;
   logic ovl_active = 1'h0;
   logic [127:0] fb_data = 128'h0;
   logic [10:0] fb_x = 11'h0;
   logic [10:0] fb_y = 11'h0;
   dpcp_pkg::dpcp_rgb_t ovl_rgb = 30'h0;
   dpcp_pkg::dpcp_rgb_t dac_rgb;
   logic dac_valid, dac_gamma;
   int failures = 0;
   int compares = 0;
   logic [32:0] exp_q[$];
   logic [31:0] ctrl = 32'h0;
   logic [31:0] w;
   logic [15:0] cur = 16'h0;
   logic [15:0] curs[4] = '{16'h0000, 16'h7FFF, 16'h8000, 16'h2A53};
   dpcp_pixel_path #(.FB_WIDTH(128), .MAX_W(2048)) dut_u (.*);
   dpcp_dac_model dac_m (.*);
   initial begin
      forever #25 aclk = ~aclk;
   end
   task automatic close_out();
      $display("Counts: %0d compares, %0d failures", compares, failures);
      if (failures == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic done;
      done = 1'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) begin
            rsp = s_axi_bresp;
            s_axi_bready <= 1'h0;
            done = 1'h1;
         end
      end
      // Idle edge so the next call never sets bready twice in one step
      @(posedge aclk);
   endtask
   task automatic rdr(input logic [7:0] a);
      logic done;
      done = 1'h0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) begin
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            s_axi_rready <= 1'h0;
            done = 1'h1;
         end
      end
      @(posedge aclk);
   endtask
   // Entry: gamma mask, colour mask, gamma, colour
   function automatic logic [32:0] model(logic [31:0] w, logic [10:0] x, logic [10:0] y,
      logic ov, logic [29:0] o);
      logic g, mr, mg, hit;
      logic [29:0] p, c;
      mr = 1'h0;
      g = 1'h1;
      p = {w[23:16], w[29:28], w[15:8], w[27:26], w[7:0], w[25:24]};
      case (ctrl[1:0])
         2'h1: g = ctrl[2] & ~w[15];
         2'h2: g = 1'h0;
         2'h3: begin
            g = ~w[31];
            mr = w[31];
         end
         default: g = 1'h1;
      endcase
      hit = ctrl[3] && x < 11'd32 && y < 11'd32 && cur != 16'h0;
      mg = !ov && !hit;
      if (ov) p = o;
      mr = mr | ov;
      c = {{2{cur[14:10]}}, {2{cur[9:5]}}, {2{cur[4:0]}}};
      if (hit) begin
         p = cur[15] ? c : p ^ c;
         mr = mr | cur[15];
      end
      return {mg, mr, g, p};
   endfunction
   task automatic pix(input logic [10:0] x, input logic [10:0] y, input logic [31:0] w,
      input logic ov, input logic f);
      logic [127:0] d;
      logic [29:0] o;
      logic [32:0] e;
      d = {$urandom, $urandom, $urandom, $urandom};
      d[ctrl[6:5]*32 +: 32] = w;
      o = 30'($urandom);
      e = model(w, x, y, ov, o);
      if (f && !ov) e[31] = 1'h0;
      exp_q.push_back(e);
      fb_valid <= 1'h1;
      fb_x <= x;
      fb_y <= y;
      fb_data <= d;
      ovl_active <= ov;
      ovl_rgb <= o;
      @(posedge aclk);
   endtask
   task automatic flush();
      logic [32:0] e;
      logic [30:0] g;
      fb_valid <= 1'h0;
      repeat (5) @(posedge aclk);
      `CHK(dac_m.got.size(), exp_q.size())
      while (exp_q.size() > 0 && dac_m.got.size() > 0) begin
         e = exp_q.pop_front();
         g = dac_m.got.pop_front();
         if (e[32]) `CHK(g[30], e[30])
         if (e[31]) `CHK(g[29:0], e[29:0])
      end
      exp_q.delete();
      dac_m.got.delete();
   endtask
   task automatic cfg(input logic [31:0] c);
      ctrl = c;
      wr(dpcp_pkg::REG_CTRL, c);
   endtask
   initial begin
      repeat (60000) @(posedge aclk);
      failures++;
      close_out();
   end
   initial begin
      void'($urandom(34741));
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      fb_vblank <= 1'h1;
      @(posedge aclk);
      rdr(dpcp_pkg::REG_CTRL);
      `CHK(rd, dpcp_pkg::CTRL_RESET)
      rdr(dpcp_pkg::REG_CURSOR_POS);
      `CHK(rd, dpcp_pkg::POS_RESET)
      rdr(8'h14);
      `CHK(rsp, 2'h2)
      wr(8'h20, 32'h1);
      `CHK(rsp, 2'h2)
      for (int m = 0; m < 8; m++) begin
         cfg({25'h0, 2'($urandom), 2'h0, 3'(m)});
         rdr(dpcp_pkg::REG_CTRL);
         `CHK(rd, ctrl)
         for (int i = 0; i < 8; i++) pix(11'(40 + i), 11'd3, $urandom, 1'h0, 1'h0);
         flush();
      end
      wr(dpcp_pkg::REG_CURSOR_BASE, 32'h0001_2000);
      wr(dpcp_pkg::REG_STATUS, 32'h0);
      repeat (3) @(posedge aclk);
      `CHK(cursor_fetch_addr, 32'h0001_2000)
      for (int i = 0; i < 3; i++) wr(dpcp_pkg::REG_CURSOR_DATA, 32'h0);
      rdr(dpcp_pkg::REG_STATUS);
      `CHK(rd[10:0], 11'h403)
      `CHK(cursor_fetch_addr, 32'h0001_2006)
      for (int k = 0; k < 4; k++) begin
         // Pattern only reloaded with the cursor off and in flyback
         cfg({25'h0, 2'($urandom), 5'h03});
         cur = curs[k];
         wr(dpcp_pkg::REG_STATUS, 32'h0);
         for (int i = 0; i < 1024; i++) wr(dpcp_pkg::REG_CURSOR_DATA, {16'h0, cur});
         cfg(ctrl | 32'h8);
         pix(11'd0, 11'd0, {1'h1, 31'($urandom)}, 1'h0, 1'h0);
         pix(11'd31, 11'd31, {1'h1, 31'($urandom)}, 1'h0, 1'h0);
         pix(11'd32, 11'd5, {1'h1, 31'($urandom)}, 1'h0, 1'h0);
         pix(11'd5, 11'd32, {1'h1, 31'($urandom)}, 1'h0, 1'h0);
         pix(11'd7, 11'd9, $urandom, 1'h1, 1'h0);
         flush();
      end
      cfg(32'h13);
      w = {8'h80, 24'($urandom)};
      for (int y = 0; y < 3; y++) begin
         // Flat field: any weights that sum to one give it back exactly
         for (int x = 0; x < 4; x++) begin
            pix(11'(x), 11'(y), w, 1'(y == 2 && x == 3), 1'(y < 2));
         end
      end
      flush();
      close_out();
   end
endmodule // dpcp_pixel_path_tb
`default_nettype wire
